// >>> bit_and_flag_instruction_unit.sv
// Bit manipulation and flag instruction execution with its status flags register.
// Assumes decode supplies one instruction with its register operand and honours ready;
// the I/O registers live here and are also reachable over an Avalon-MM slave.
//
// What this block does
// - Set I/O bit to one, two cycles.
// - Clear I/O bit to zero, two cycles.
// - Rotate left through carry, update flags.
// - Rotate right through carry, update flags.
// - Copy register bit into transfer flag.
// - Copy transfer flag into register bit.
// - Opcodes set or clear overflow flag.
// - Opcodes set or clear half-carry flag.
// - Opcodes set or clear signed-test flag.
// - Sleep takes one cycle, signals power logic.
// - Watchdog restart one cycle, pulses watchdog.
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module bit_and_flag_instruction_unit
    import bit_flag_pkg::*;
#(
    parameter int IO_DEPTH = IO_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire instr_t instr,
    output logic instr_ready,
    output result_t result,
    output logic [DATA_W-1:0] status_flags,
    output logic sleep_request,
    output logic watchdog_restart,
    input wire logic [BUS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [BUS_DATA_W-1:0] avs_writedata,
    input wire logic [BUS_BE_W-1:0] avs_byteenable,
    output logic [BUS_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest
);

    // One-hot mask for a bit position
    function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_SEL_W-1:0] sel);
        logic [DATA_W-1:0] m;
        m = '0;
        m[sel] = 1'b1;
        return m;
    endfunction

    // Flags after a rotate; S and H are left alone on purpose
    function automatic logic [DATA_W-1:0] rotate_flags(
        input logic [DATA_W-1:0] flags,
        input logic [DATA_W-1:0] res,
        input logic carry_out
    );
        logic [DATA_W-1:0] f;
        f = flags;
        f[FLAG_C] = carry_out;
        f[FLAG_Z] = (res == '0);
        f[FLAG_N] = res[DATA_W-1];
        f[FLAG_V] = res[DATA_W-1] ^ carry_out;
        return f;
    endfunction

    // True when a bus address falls in the I/O window
    function automatic logic is_io_window(input logic [BUS_ADDR_W-1:0] a);
        return a[BUS_ADDR_W-1:IO_WINDOW_PAGE_LSB] == IO_WINDOW_PAGE;
    endfunction

    function automatic logic is_io_op(input op_t op);
        return (op == OP_SET_IO_REGISTER_BIT) || (op == OP_CLEAR_IO_REGISTER_BIT);
    endfunction

    exec_state_t exec_state_reg;
    exec_state_t exec_state_next;
    logic [DATA_W-1:0] status_reg;
    logic [DATA_W-1:0] status_next;
    result_t result_reg;
    result_t result_next;
    logic sleep_reg;
    logic sleep_next;
    logic slept_reg;
    logic slept_next;
    logic wdr_reg;
    logic wdr_next;
    logic [BUS_DATA_W-1:0] wdr_count_reg;
    logic [BUS_DATA_W-1:0] wdr_count_next;
    logic [IO_ADDR_W-1:0] hold_addr_reg;
    logic [IO_ADDR_W-1:0] hold_addr_next;
    logic [BIT_SEL_W-1:0] hold_bit_reg;
    logic [BIT_SEL_W-1:0] hold_bit_next;
    logic hold_set_reg;
    logic hold_set_next;
    bus_state_t bus_state_reg;
    bus_state_t bus_state_next;
    logic [BUS_DATA_W-1:0] readdata_reg;
    logic [BUS_DATA_W-1:0] readdata_next;
    logic resp_io_reg;
    logic resp_io_next;
    logic accept;
    logic bus_start;
    logic bus_io;
    logic mem_we;
    logic [IO_ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] mem_wdata;
    logic [DATA_W-1:0] mem_rdata;

    // Instructions own the I/O port; the bus only runs while execution is idle
    assign instr_ready = (exec_state_reg == EX_READY) && (bus_state_reg == BUS_IDLE);
    assign accept = instr_valid && instr_ready;
    assign bus_io = is_io_window(avs_address);
    assign bus_start = (avs_read || avs_write) && !instr_valid && (exec_state_reg == EX_READY)
        && (bus_state_reg == BUS_IDLE);

    io_space_ram #(
        .WIDTH(DATA_W),
        .DEPTH(IO_DEPTH),
        .ADDR_W(IO_ADDR_W)
    ) io_space (
        .clk(clk),
        .rst_n(rst_n),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // I/O port steering: read-modify-write second half first, then new read, then bus
    always_comb begin
        mem_we = 1'b0;
        mem_addr = '0;
        mem_wdata = '0;
        if (exec_state_reg == EX_IO_WRITE) begin
            mem_we = 1'b1;
            mem_addr = hold_addr_reg;
            if (hold_set_reg) begin
                mem_wdata = mem_rdata | bit_mask(hold_bit_reg);
            end else begin
                mem_wdata = mem_rdata & ~bit_mask(hold_bit_reg);
            end
        end else if (accept && is_io_op(instr.op)) begin
            mem_addr = instr.io_addr;
        end else if (bus_state_reg == BUS_RESP && bus_io) begin
            mem_addr = avs_address[IO_INDEX_LSB +: IO_ADDR_W];
            mem_we = avs_write && avs_byteenable[0];
            mem_wdata = avs_writedata[DATA_W-1:0];
        end else if (bus_start && bus_io) begin
            mem_addr = avs_address[IO_INDEX_LSB +: IO_ADDR_W];
        end
    end

    // Execution next state; every flag not named by an op is copied through
    always_comb begin
        exec_state_next = exec_state_reg;
        status_next = status_reg;
        result_next = '0;
        sleep_next = 1'b0;
        slept_next = slept_reg;
        wdr_next = 1'b0;
        wdr_count_next = wdr_count_reg;
        hold_addr_next = hold_addr_reg;
        hold_bit_next = hold_bit_reg;
        hold_set_next = hold_set_reg;
        if (exec_state_reg == EX_IO_WRITE) begin
            exec_state_next = EX_READY;
        end else if (bus_state_reg == BUS_RESP && avs_write && avs_address == ADDR_STATUS_FLAGS
            && avs_byteenable[0]) begin
            status_next = avs_writedata[DATA_W-1:0];
        end else if (accept) begin
            result_next.index = instr.reg_index;
            case (instr.op)
                OP_SET_IO_REGISTER_BIT,
                OP_CLEAR_IO_REGISTER_BIT: begin
                    // Status untouched; the write lands on the second cycle
                    exec_state_next = EX_IO_WRITE;
                    hold_addr_next = instr.io_addr;
                    hold_bit_next = instr.bit_sel;
                    hold_set_next = (instr.op == OP_SET_IO_REGISTER_BIT);
                end
                OP_ROTATE_LEFT_VIA_CARRY: begin
                    result_next.write = 1'b1;
                    result_next.value = {instr.reg_value[DATA_W-2:0],
                        status_reg[FLAG_C]};
                    status_next = rotate_flags(status_reg, result_next.value,
                        instr.reg_value[DATA_W-1]);
                end
                OP_ROTATE_RIGHT_VIA_CARRY: begin
                    result_next.write = 1'b1;
                    result_next.value = {status_reg[FLAG_C],
                        instr.reg_value[DATA_W-1:1]};
                    status_next = rotate_flags(status_reg, result_next.value,
                        instr.reg_value[0]);
                end
                OP_STORE_BIT_TO_TRANSFER_FLAG: begin
                    status_next[FLAG_T] = instr.reg_value[instr.bit_sel];
                end
                OP_LOAD_BIT_FROM_TRANSFER_FLAG: begin
                    result_next.write = 1'b1;
                    if (status_reg[FLAG_T]) begin
                        result_next.value = instr.reg_value | bit_mask(instr.bit_sel);
                    end else begin
                        result_next.value = instr.reg_value & ~bit_mask(instr.bit_sel);
                    end
                end
                OP_SET_OVERFLOW_FLAG: begin
                    status_next[FLAG_V] = 1'b1;
                end
                OP_CLEAR_OVERFLOW_FLAG: begin
                    status_next[FLAG_V] = 1'b0;
                end
                OP_SET_HALF_CARRY_FLAG: begin
                    status_next[FLAG_H] = 1'b1;
                end
                OP_CLEAR_HALF_CARRY_FLAG: begin
                    status_next[FLAG_H] = 1'b0;
                end
                OP_SET_SIGN_FLAG: begin
                    status_next[FLAG_S] = 1'b1;
                end
                OP_CLEAR_SIGN_FLAG: begin
                    status_next[FLAG_S] = 1'b0;
                end
                OP_SLEEP: begin
                    sleep_next = 1'b1;
                    slept_next = 1'b1;
                end
                OP_WATCHDOG_RESTART: begin
                    wdr_next = 1'b1;
                    wdr_count_next = wdr_count_reg + 1'b1;
                end
                default: begin
                    result_next.index = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            exec_state_reg <= EX_READY;
            status_reg <= STATUS_RESET;
            result_reg <= '0;
            sleep_reg <= 1'b0;
            slept_reg <= 1'b0;
            wdr_reg <= 1'b0;
            wdr_count_reg <= '0;
            hold_addr_reg <= '0;
            hold_bit_reg <= '0;
            hold_set_reg <= 1'b0;
        end else begin
            exec_state_reg <= exec_state_next;
            status_reg <= status_next;
            result_reg <= result_next;
            sleep_reg <= sleep_next;
            slept_reg <= slept_next;
            wdr_reg <= wdr_next;
            wdr_count_reg <= wdr_count_next;
            hold_addr_reg <= hold_addr_next;
            hold_bit_reg <= hold_bit_next;
            hold_set_reg <= hold_set_next;
        end
    end

    // Bus slave: every access takes at least one wait cycle so read data come from flops
    always_comb begin
        bus_state_next = bus_state_reg;
        readdata_next = readdata_reg;
        resp_io_next = resp_io_reg;
        case (bus_state_reg)
            BUS_IDLE: begin
                if (bus_start) begin
                    bus_state_next = BUS_RESP;
                    resp_io_next = bus_io;
                    readdata_next = '0;
                    if (avs_address == ADDR_STATUS_FLAGS) begin
                        readdata_next[DATA_W-1:0] = status_reg;
                    end else if (avs_address == ADDR_UNIT_STATE) begin
                        readdata_next[STATE_BUSY_BIT] = (exec_state_reg != EX_READY);
                        readdata_next[STATE_SLEPT_BIT] = slept_reg;
                    end else if (avs_address == ADDR_WDR_COUNT) begin
                        readdata_next = wdr_count_reg;
                    end
                end
            end
            BUS_RESP: begin
                bus_state_next = BUS_IDLE;
            end
            default: begin
                bus_state_next = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_reg <= BUS_IDLE;
            readdata_reg <= '0;
            resp_io_reg <= 1'b0;
        end else begin
            bus_state_reg <= bus_state_next;
            readdata_reg <= readdata_next;
            resp_io_reg <= resp_io_next;
        end
    end

    // Waitrequest stays high outside the answer cycle, which Avalon allows
    assign avs_waitrequest = (bus_state_reg != BUS_RESP);
    assign avs_readdata = resp_io_reg ? {{(BUS_DATA_W-DATA_W){1'b0}}, mem_rdata} : readdata_reg;
    assign result = result_reg;
    assign status_flags = status_reg;
    assign sleep_request = sleep_reg;
    assign watchdog_restart = wdr_reg;

endmodule

// >>> bit_flag_pkg.sv
// Shared constants, opcode encoding and carrier types for the bit and flag unit.
// Assumes a single 100 MHz core clock and an Avalon-MM slave with byte addressing.
package bit_flag_pkg;

    // Data widths
    localparam int DATA_W = 8;
    localparam int BIT_SEL_W = 3;
    localparam int REG_INDEX_W = 5;
    localparam int IO_ADDR_W = 6;
    localparam int IO_DEPTH_DEF = 64;
    localparam int BUS_ADDR_W = 10;
    localparam int BUS_DATA_W = 32;
    localparam int BUS_BE_W = 4;

    // Status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Register map, byte addresses
    localparam logic [BUS_ADDR_W-1:0] ADDR_STATUS_FLAGS = 10'h000;
    localparam logic [BUS_ADDR_W-1:0] ADDR_UNIT_STATE = 10'h004;
    localparam logic [BUS_ADDR_W-1:0] ADDR_WDR_COUNT = 10'h008;
    localparam logic [1:0] IO_WINDOW_PAGE = 2'h1;
    localparam int IO_WINDOW_PAGE_LSB = 8;
    localparam int IO_INDEX_LSB = 2;
    localparam int STATE_BUSY_BIT = 0;
    localparam int STATE_SLEPT_BIT = 1;

    // Instruction codes from decode
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_SET_IO_REGISTER_BIT = 4'h1,
        OP_CLEAR_IO_REGISTER_BIT = 4'h2,
        OP_ROTATE_LEFT_VIA_CARRY = 4'h3,
        OP_ROTATE_RIGHT_VIA_CARRY = 4'h4,
        OP_STORE_BIT_TO_TRANSFER_FLAG = 4'h5,
        OP_LOAD_BIT_FROM_TRANSFER_FLAG = 4'h6,
        OP_SET_OVERFLOW_FLAG = 4'h7,
        OP_CLEAR_OVERFLOW_FLAG = 4'h8,
        OP_SET_HALF_CARRY_FLAG = 4'h9,
        OP_CLEAR_HALF_CARRY_FLAG = 4'ha,
        OP_SET_SIGN_FLAG = 4'hb,
        OP_CLEAR_SIGN_FLAG = 4'hc,
        OP_SLEEP = 4'hd,
        OP_WATCHDOG_RESTART = 4'he
    } op_t;

    // Execution states, Gray along ready -> io write -> ready
    typedef enum logic [1:0] {
        EX_READY = 2'b00,
        EX_IO_WRITE = 2'b01
    } exec_state_t;

    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_RESP = 2'b01
    } bus_state_t;

    // One instruction from decode, with the general register operand already read
    typedef struct packed {
        op_t op;
        logic [BIT_SEL_W-1:0] bit_sel;
        logic [IO_ADDR_W-1:0] io_addr;
        logic [REG_INDEX_W-1:0] reg_index;
        logic [DATA_W-1:0] reg_value;
    } instr_t;

    // Write-back of a general register
    typedef struct packed {
        logic write;
        logic [REG_INDEX_W-1:0] index;
        logic [DATA_W-1:0] value;
    } result_t;

endpackage

// >>> io_space_ram.sv
// Single-port I/O register storage with registered read data.
// Assumes one owner of the port per cycle; the caller arbitrates.
`timescale 1ns/10ps
module io_space_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int ADDR_W = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rdata_reg;
    logic [WIDTH-1:0] rdata_next;

    // Read-before-write: the old word is returned, which suits read-modify-write
    always_comb begin
        rdata_next = mem[addr];
    end

    // Storage has no reset, only the read register does
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;

endmodule

// >>> bit_flag_checker.sv
// Concurrent checks on the bit and flag unit, seen only through its top ports.
// Assumes one core clock and an active low asynchronous reset.
`timescale 1ns/10ps
module bit_flag_checker
    import bit_flag_pkg::*;
#(
    parameter int IO_DEPTH = IO_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire instr_t instr,
    input wire logic instr_ready,
    input wire result_t result,
    input wire logic [DATA_W-1:0] status_flags,
    input wire logic sleep_request,
    input wire logic watchdog_restart
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Accepted instruction, shared by every property
    logic acc;
    assign acc = instr_valid && instr_ready;

    rol_result_a: assert property (acc && instr.op == OP_ROTATE_LEFT_VIA_CARRY |=>
        result.write && result.value == {$past(instr.reg_value[6:0]), $past(status_flags[FLAG_C])}
        && status_flags[FLAG_C] == $past(instr.reg_value[7])) else $error("rotate left wrong");
    ror_result_a: assert property (acc && instr.op == OP_ROTATE_RIGHT_VIA_CARRY |=>
        result.write && result.value == {$past(status_flags[FLAG_C]), $past(instr.reg_value[7:1])}
        && status_flags[FLAG_C] == $past(instr.reg_value[0])) else $error("rotate right wrong");
    bst_flag_a: assert property (acc && instr.op == OP_STORE_BIT_TO_TRANSFER_FLAG |=>
        status_flags[FLAG_T] == $past(instr.reg_value[instr.bit_sel])
        && (status_flags | 8'h40) == ($past(status_flags) | 8'h40)) else $error("bit store wrong");
    bld_value_a: assert property (acc && instr.op == OP_LOAD_BIT_FROM_TRANSFER_FLAG |=>
        result.write && result.value[$past(instr.bit_sel)] == status_flags[FLAG_T]
        && (result.value | (8'h01 << $past(instr.bit_sel)))
        == ($past(instr.reg_value) | (8'h01 << $past(instr.bit_sel)))
        && $stable(status_flags)) else $error("bit load wrong");
    io_two_cycle_a: assert property (acc && instr.op inside {
        OP_SET_IO_REGISTER_BIT, OP_CLEAR_IO_REGISTER_BIT}
        |=> (!instr_ready && $stable(status_flags)) ##1 instr_ready)
        else $error("io bit op timing wrong");
    ov_flag_a: assert property (acc && instr.op inside {OP_SET_OVERFLOW_FLAG,
        OP_CLEAR_OVERFLOW_FLAG} |=> status_flags == ($past(instr.op) == OP_SET_OVERFLOW_FLAG ?
        $past(status_flags) | 8'h08 : $past(status_flags) & 8'hf7))
        else $error("overflow op wrong");
    half_flag_a: assert property (acc && instr.op inside {OP_SET_HALF_CARRY_FLAG,
        OP_CLEAR_HALF_CARRY_FLAG} |=> status_flags == ($past(instr.op) == OP_SET_HALF_CARRY_FLAG ?
        $past(status_flags) | 8'h20 : $past(status_flags) & 8'hdf)) else $error("half op wrong");
    sign_flag_a: assert property (acc && instr.op inside {OP_SET_SIGN_FLAG,
        OP_CLEAR_SIGN_FLAG} |=> status_flags == ($past(instr.op) == OP_SET_SIGN_FLAG ?
        $past(status_flags) | 8'h10 : $past(status_flags) & 8'hef)) else $error("sign op wrong");
    sleep_pulse_a: assert property (acc && instr.op == OP_SLEEP |=>
        sleep_request && $stable(status_flags) ##1 !sleep_request)
        else $error("sleep pulse wrong");
    wdr_pulse_a: assert property (acc && instr.op == OP_WATCHDOG_RESTART |=>
        watchdog_restart && $stable(status_flags) ##1 !watchdog_restart)
        else $error("watchdog pulse wrong");
endmodule

bind bit_and_flag_instruction_unit bit_flag_checker #(.IO_DEPTH(IO_DEPTH)) u_chk (
    .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .result(result), .status_flags(status_flags),
    .sleep_request(sleep_request), .watchdog_restart(watchdog_restart));

// >>> bit_and_flag_instruction_unit_test.sv
// Self-checking bench for the bit and flag unit: instruction port and register bus.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/10ps
module bit_and_flag_instruction_unit_test
    import bit_flag_pkg::*;
    ();
    logic clk, rst_n, instr_valid, instr_ready, sleep_request, watchdog_restart;
    instr_t instr;
    result_t result;
    logic [DATA_W-1:0] status_flags, exp_f;
    logic [BUS_ADDR_W-1:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [BUS_DATA_W-1:0] avs_writedata, avs_readdata, rd;
    logic [BUS_BE_W-1:0] avs_byteenable;
    int error_cnt, total_checks, cycles;
    op_t fops[6] = '{OP_SET_OVERFLOW_FLAG, OP_CLEAR_OVERFLOW_FLAG, OP_SET_HALF_CARRY_FLAG,
        OP_CLEAR_HALF_CARRY_FLAG, OP_SET_SIGN_FLAG, OP_CLEAR_SIGN_FLAG};
    logic [7:0] fmask[6] = '{8'h08, 8'h08, 8'h20, 8'h20, 8'h10, 8'h10};

    bit_and_flag_instruction_unit u_dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr(instr), .instr_ready(instr_ready), .result(result), .status_flags(status_flags),
        .sleep_request(sleep_request), .watchdog_restart(watchdog_restart),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    // Free running core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(string name, logic [31:0] seen, logic [31:0] expv);
        total_checks++;
        if (seen !== expv) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, expv, seen);
        end
    endtask

    // Offer one instruction, hold it until accepted, then let the edge settle
    task automatic exec(op_t op, logic [2:0] b, logic [5:0] a, logic [7:0] v);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= '{op, b, a, 5'h03, v};
        do @(posedge clk); while (!instr_ready);
        instr_valid <= 1'b0;
        #1;
    endtask

    // One Avalon access; the request stands until waitrequest is seen low
    task automatic bus(logic wr, logic [9:0] a, logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (avs_waitrequest);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // Hang guard: well above the hundred or so cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    initial begin
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr = '0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hf;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, 10'h000, 32'h0000_0000);
        check("status reset", rd, 32'h0000_0000);
        // Rotations with S, H and T set so that untouched flags are visible
        bus(1'b1, 10'h000, 32'h0000_0071);
        exec(OP_ROTATE_LEFT_VIA_CARRY, 3'h0, 6'h00, 8'h80);
        check("rol value", {result.write, result.value}, 32'h0000_0101);
        check("rol flags", status_flags, 32'h0000_0079);
        exec(OP_ROTATE_RIGHT_VIA_CARRY, 3'h0, 6'h00, 8'h02);
        check("ror value", {result.write, result.value}, 32'h0000_0181);
        check("ror flags", status_flags, 32'h0000_007c);
        exec(OP_ROTATE_LEFT_VIA_CARRY, 3'h0, 6'h00, 8'h00);
        check("rol zero flags", status_flags, 32'h0000_0072);
        // Transfer flag in and out of a general register
        exec(OP_STORE_BIT_TO_TRANSFER_FLAG, 3'h4, 6'h00, 8'h20);
        check("bst clear", status_flags, 32'h0000_0032);
        // Bit load with the transfer flag clear must keep every other bit
        exec(OP_LOAD_BIT_FROM_TRANSFER_FLAG, 3'h2, 6'h00, 8'ha5);
        check("bld clear", {result.write, result.value}, 32'h0000_01a1);
        exec(OP_STORE_BIT_TO_TRANSFER_FLAG, 3'h5, 6'h00, 8'h20);
        check("bst set", status_flags, 32'h0000_0072);
        check("bst no write", result.write, 32'h0000_0000);
        exec(OP_LOAD_BIT_FROM_TRANSFER_FLAG, 3'h0, 6'h00, 8'h00);
        check("bld value", {result.write, result.index, result.value}, 32'h0000_2301);
        check("bld flags", status_flags, 32'h0000_0072);
        exec(OP_LOAD_BIT_FROM_TRANSFER_FLAG, 3'h3, 6'h00, 8'ha5);
        check("bld keep", {result.write, result.value}, 32'h0000_01ad);
        // Every dedicated flag opcode from a mixed starting pattern
        bus(1'b1, 10'h000, 32'h0000_00c7);
        exp_f = 8'hc7;
        for (int i = 0; i < 6; i++) begin
            exp_f = (i % 2 == 0) ? (exp_f | fmask[i]) : (exp_f & ~fmask[i]);
            exec(fops[i], 3'h0, 6'h00, 8'h00);
            check("flag op", status_flags, {24'h00_0000, exp_f});
        end
        // Read-modify-write of I/O registers, including the last one
        bus(1'b1, 10'h114, 32'h0000_000f);
        exec(OP_SET_IO_REGISTER_BIT, 3'h7, 6'h05, 8'h00);
        check("io busy", instr_ready, 32'h0000_0000);
        bus(1'b0, 10'h114, 32'h0000_0000);
        check("io set", rd, 32'h0000_008f);
        exec(OP_CLEAR_IO_REGISTER_BIT, 3'h0, 6'h05, 8'h00);
        check("io clear busy", instr_ready, 32'h0000_0000);
        bus(1'b0, 10'h114, 32'h0000_0000);
        check("io clear", rd, 32'h0000_008e);
        bus(1'b1, 10'h1fc, 32'h0000_0000);
        exec(OP_SET_IO_REGISTER_BIT, 3'h0, 6'h3f, 8'h00);
        bus(1'b0, 10'h1fc, 32'h0000_0000);
        check("io last", rd, 32'h0000_0001);
        check("io flags", status_flags, {24'h00_0000, exp_f});
        // Sleep and watchdog pulses last exactly one cycle
        exec(OP_SLEEP, 3'h0, 6'h00, 8'h00);
        check("sleep pulse", sleep_request, 32'h0000_0001);
        @(posedge clk);
        #1;
        check("sleep end", sleep_request, 32'h0000_0000);
        bus(1'b0, 10'h004, 32'h0000_0000);
        check("unit state", rd, 32'h0000_0002);
        exec(OP_WATCHDOG_RESTART, 3'h0, 6'h00, 8'h00);
        check("wdr pulse", watchdog_restart, 32'h0000_0001);
        exec(OP_WATCHDOG_RESTART, 3'h0, 6'h00, 8'h00);
        bus(1'b0, 10'h008, 32'h0000_0000);
        check("wdr count", rd, 32'h0000_0002);
        check("quiet flags", status_flags, {24'h00_0000, exp_f});
        bus(1'b1, 10'h00c, 32'h0000_00ff);
        bus(1'b0, 10'h00c, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        tally_and_finish();
    end
endmodule
